// ===== kwio_regs.vh
`ifndef KWIO_REGS_VH
`define KWIO_REGS_VH
// register offsets on the byte-wide internal bus
`define KWIO_OFS_A_DATA   8'h28
`define KWIO_OFS_B_DATA   8'h29
`define KWIO_OFS_A_DIR    8'h2a
`define KWIO_OFS_B_DIR    8'h2b
`define KWIO_OFS_A_EN     8'h2c
`define KWIO_OFS_B_EN     8'h2d
`define KWIO_OFS_A_FLAG   8'h2e
`define KWIO_OFS_B_FLAG   8'h2f
// field positions
`define KWIO_I2C_SEL_BIT  7
`define KWIO_SDA_BIT      6
`define KWIO_SCL_BIT      7
// reset values
`define KWIO_RST_BYTE     8'h00
`define KWIO_RST_CNT      2'h0
// filter: one sample per oscillator tick, three samples in all, two must agree
`define KWIO_OSC_DIV      4'h4
`define KWIO_VOTE_LAST    2'h2
`endif

// ===== kwio_sync.v
// three-stage pin synchroniser; a change counts when stages two and three agree
module kwio_sync #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;

  // idle high so a pin that rests high does not fake a falling edge
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= {W{1'b1}};
      s2_r <= {W{1'b1}};
      s3_r <= {W{1'b1}};
      dout <= {W{1'b1}};
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s2_r[i];
        end
      end
    end
  end
endmodule

// ===== kwio_top.v
// Operation
// R1: sixteen pins, fifteen wake, top pin I2C
// R2: wake event is a pin falling edge
// R3: request when flag and enable both set
// R4: all sources share one request output
// R5: edges flagged in input or output direction
// R6: unclocked pin-to-request path during STOP
// R7: pull-up when pull-select high, else down
// R8: direction 0 input, 1 output, always accessible
// R9: enable bit 7 selects I2C start detection
// R10: I2C mode makes pins six, seven open-drain
// R11: start needs data fall while clock high; here a clock rise with data low also flags
// R12: enable/flag six follow selected event
// R13: enables gate per pin, reset to zero
// R14: falling edge sets flag, write one clears
// R15: first port flag bit 7 reads zero
// R16: filter active only in STOP
// R17: filter oscillator starts on enabled edge
// R18: three samples, two low sets flag
// R19: one filter shared by all enabled pins
// R20: close pulses may merge into one
// R21: software avoids floating inputs
// R22: outside STOP, synchronised high-then-low edge
//
// Chosen here: the strobed register port.
`include "kwio_regs.vh"
module kwio_top #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire [7:0]   bus_addr,
  input  wire [7:0]   bus_wdata,
  input  wire         bus_wr,
  input  wire         bus_rd,
  output reg  [7:0]   bus_rdata,
  input  wire         stop_mode,
  input  wire [W-1:0] port_a_in,
  output reg  [W-1:0] port_a_out,
  output reg  [W-1:0] port_a_oe_n,
  input  wire [W-1:0] port_b_in,
  output reg  [W-1:0] port_b_out,
  output reg  [W-1:0] port_b_oe_n,
  input  wire         port_a_pull_select,
  input  wire         port_b_pull_select,
  output reg          port_a_pull_up,
  output reg          port_b_pull_up,
  output reg          key_wakeup_irq,
  output wire         key_wakeup_stop_wake
);
  reg  [W-1:0] a_data_r;
  reg  [W-1:0] b_data_r;
  reg  [W-1:0] a_dir_r;
  reg  [W-1:0] b_dir_r;
  reg  [W-1:0] a_en_r;
  reg  [W-1:0] b_en_r;
  reg  [W-1:0] a_flag_r;
  reg  [W-1:0] b_flag_r;
  reg  [W-1:0] a_flag_nxt;
  reg  [W-1:0] b_flag_nxt;
  reg  [W-1:0] a_prev_r;
  reg  [W-1:0] b_prev_r;
  reg          start_prev_r;
  wire [W-1:0] a_sync;
  wire [W-1:0] b_sync;
  wire         i2c_sel;
  wire         start_lvl;
  wire [W-1:0] a_evt_lvl;
  wire [W-1:0] a_fall;
  wire [W-1:0] b_fall;
  wire         start_fall;

  // filter state
  reg          flt_run_r;
  reg  [3:0]   flt_div_r;
  reg  [1:0]   flt_smp_r;
  reg  [1:0]   flt_votes_r;
  reg  [W-1:0] a_cand_r;
  reg  [W-1:0] b_cand_r;
  reg  [W-1:0] a_fset;
  reg  [W-1:0] b_fset;

  assign i2c_sel = a_en_r[`KWIO_I2C_SEL_BIT];

  kwio_sync #(.W(W)) u_sync_a (
    .clk  (clk),
    .nrst (nrst),
    .din  (port_a_in),
    .dout (a_sync)
  );

  kwio_sync #(.W(W)) u_sync_b (
    .clk  (clk),
    .nrst (nrst),
    .din  (port_b_in),
    .dout (b_sync)
  );

  // start event level: data low while clock high; low means asserted [R11]
  assign start_lvl = ~(~a_sync[`KWIO_SDA_BIT] & a_sync[`KWIO_SCL_BIT]);

  // pin six watches either its own level or the start level [R9] [R12]
  assign a_evt_lvl = i2c_sel ?
    {1'b1, start_lvl, a_sync[W-3:0]} : {1'b1, a_sync[W-2:0]};

  // edge taken from the pin level itself, so direction does not matter [R2] [R5] [R22]
  assign a_fall     = a_prev_r & ~a_evt_lvl;
  assign b_fall     = b_prev_r & ~b_sync;
  assign start_fall = start_prev_r & ~start_lvl;

  // unclocked wake path for STOP: raw pin low on any enabled source [R6] [R4]
  assign key_wakeup_stop_wake = stop_mode & (
    |(~port_a_in[W-2:0] & a_en_r[W-2:0]) |
    |(~port_b_in & b_en_r));

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_prev_r     <= {W{1'b1}};
      b_prev_r     <= {W{1'b1}};
      start_prev_r <= 1'b1;
    end else begin
      a_prev_r     <= a_evt_lvl;
      b_prev_r     <= b_sync;
      start_prev_r <= start_lvl;
    end
  end

  // shared majority filter, clocked by a divided tick in STOP [R16] [R19]
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flt_run_r   <= 1'b0;
      flt_div_r   <= 4'h0;
      flt_smp_r   <= `KWIO_RST_CNT;
      flt_votes_r <= `KWIO_RST_CNT;
      a_cand_r    <= `KWIO_RST_BYTE;
      b_cand_r    <= `KWIO_RST_BYTE;
    end else if (!stop_mode) begin
      flt_run_r   <= 1'b0;
      flt_div_r   <= 4'h0;
      flt_smp_r   <= `KWIO_RST_CNT;
      flt_votes_r <= `KWIO_RST_CNT;
      a_cand_r    <= `KWIO_RST_BYTE;
      b_cand_r    <= `KWIO_RST_BYTE;
    end else if (!flt_run_r) begin
      // oscillator starts only on an enabled edge [R17]
      if (|(a_fall & a_en_r) || |(b_fall & b_en_r)) begin
        flt_run_r <= 1'b1;
        a_cand_r  <= a_fall & a_en_r;
        b_cand_r  <= b_fall & b_en_r;
      end
    end else begin
      // later edges join the same window; close pulses merge [R20]
      a_cand_r <= a_cand_r | (a_fall & a_en_r);
      b_cand_r <= b_cand_r | (b_fall & b_en_r);
      if (flt_div_r == `KWIO_OSC_DIV) begin
        flt_div_r <= 4'h0;
        if (flt_smp_r == `KWIO_VOTE_LAST) begin
          flt_smp_r   <= `KWIO_RST_CNT;
          flt_votes_r <= `KWIO_RST_CNT;
          flt_run_r   <= 1'b0;
        end else begin
          flt_smp_r <= flt_smp_r + 2'h1;
          if (|(a_cand_r & ~a_evt_lvl) || |(b_cand_r & ~b_sync)) begin
            flt_votes_r <= flt_votes_r + 2'h1;
          end
        end
      end else begin
        flt_div_r <= flt_div_r + 4'h1;
      end
    end
  end

  // flag set sources: raw edge outside STOP, vote result inside [R18]
  always @* begin
    a_fset = `KWIO_RST_BYTE;
    b_fset = `KWIO_RST_BYTE;
    if (!stop_mode) begin
      a_fset = a_fall;
      b_fset = b_fall;
    end else if (flt_run_r && flt_div_r == `KWIO_OSC_DIV &&
                 flt_smp_r == `KWIO_VOTE_LAST) begin
      // third sample: two of three low means valid
      if (flt_votes_r + {1'b0, (|(a_cand_r & ~a_evt_lvl) ||
          |(b_cand_r & ~b_sync))} >= `KWIO_VOTE_LAST) begin
        a_fset = a_cand_r & ~a_evt_lvl | a_cand_r;
        b_fset = b_cand_r;
      end
    end
    a_fset[W-1] = 1'b0; // top pin never flags [R1] [R15]
  end

  // w1c flags; a set in the same cycle as the clear wins [R14]
  always @* begin
    a_flag_nxt = a_flag_r;
    b_flag_nxt = b_flag_r;
    if (bus_wr && bus_addr == `KWIO_OFS_A_FLAG) begin
      a_flag_nxt = a_flag_nxt & ~bus_wdata;
    end
    if (bus_wr && bus_addr == `KWIO_OFS_B_FLAG) begin
      b_flag_nxt = b_flag_nxt & ~bus_wdata;
    end
    a_flag_nxt = a_flag_nxt | a_fset;
    b_flag_nxt = b_flag_nxt | b_fset;
  end

  // register writes; direction and enable always writable [R8] [R13]
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_data_r <= `KWIO_RST_BYTE;
      b_data_r <= `KWIO_RST_BYTE;
      a_dir_r  <= `KWIO_RST_BYTE;
      b_dir_r  <= `KWIO_RST_BYTE;
      a_en_r   <= `KWIO_RST_BYTE;
      b_en_r   <= `KWIO_RST_BYTE;
      a_flag_r <= `KWIO_RST_BYTE;
      b_flag_r <= `KWIO_RST_BYTE;
    end else begin
      a_flag_r <= a_flag_nxt;
      b_flag_r <= b_flag_nxt;
      if (bus_wr) begin
        case (bus_addr)
          `KWIO_OFS_A_DATA: a_data_r <= bus_wdata;
          `KWIO_OFS_B_DATA: b_data_r <= bus_wdata;
          `KWIO_OFS_A_DIR:  a_dir_r  <= bus_wdata;
          `KWIO_OFS_B_DIR:  b_dir_r  <= bus_wdata;
          `KWIO_OFS_A_EN:   a_en_r   <= bus_wdata;
          `KWIO_OFS_B_EN:   b_en_r   <= bus_wdata;
          default: ;
        endcase
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_rdata <= `KWIO_RST_BYTE;
    end else if (bus_rd) begin
      case (bus_addr)
        `KWIO_OFS_A_DATA: bus_rdata <= a_sync;
        `KWIO_OFS_B_DATA: bus_rdata <= b_sync;
        `KWIO_OFS_A_DIR:  bus_rdata <= a_dir_r;
        `KWIO_OFS_B_DIR:  bus_rdata <= b_dir_r;
        `KWIO_OFS_A_EN:   bus_rdata <= a_en_r;
        `KWIO_OFS_B_EN:   bus_rdata <= b_en_r;
        `KWIO_OFS_A_FLAG: bus_rdata <= {1'b0, a_flag_r[W-2:0]}; // [R15]
        `KWIO_OFS_B_FLAG: bus_rdata <= b_flag_r;
        default:          bus_rdata <= `KWIO_RST_BYTE;
      endcase
    end else begin
      bus_rdata <= `KWIO_RST_BYTE;
    end
  end

  // pin drivers and request, all registered
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_a_out     <= `KWIO_RST_BYTE;
      port_b_out     <= `KWIO_RST_BYTE;
      port_a_oe_n    <= {W{1'b1}};
      port_b_oe_n    <= {W{1'b1}};
      port_a_pull_up <= 1'b0;
      port_b_pull_up <= 1'b0;
      key_wakeup_irq <= 1'b0;
    end else begin
      port_a_out  <= a_data_r;
      port_b_out  <= b_data_r;
      port_a_oe_n <= ~a_dir_r; // [R8]
      port_b_oe_n <= ~b_dir_r;
      if (i2c_sel) begin
        // open drain: drive only a low, release for a high [R10]
        port_a_out[`KWIO_SDA_BIT]  <= 1'b0;
        port_a_out[`KWIO_SCL_BIT]  <= 1'b0;
        port_a_oe_n[`KWIO_SDA_BIT] <= ~(a_dir_r[`KWIO_SDA_BIT] & ~a_data_r[`KWIO_SDA_BIT]);
        port_a_oe_n[`KWIO_SCL_BIT] <= ~(a_dir_r[`KWIO_SCL_BIT] & ~a_data_r[`KWIO_SCL_BIT]);
      end
      port_a_pull_up <= port_a_pull_select; // [R7]
      port_b_pull_up <= port_b_pull_select;
      // one shared request from every flag and enable pair [R3] [R4]
      key_wakeup_irq <= |(a_flag_nxt[W-2:0] & a_en_r[W-2:0]) |
                        |(b_flag_nxt & b_en_r);
    end
  end
endmodule

// ===== kwio_monitor.sv
`include "kwio_regs.vh"
module kwio_monitor #(
  parameter W = 8
) (
  input logic         clk,
  input logic         nrst,
  input logic [7:0]   bus_addr,
  input logic         bus_wr,
  input logic         bus_rd,
  input logic [7:0]   bus_rdata,
  input logic         stop_mode,
  input logic [W-1:0] port_a_in,
  input logic [W-1:0] port_b_in,
  input logic [W-1:0] port_a_oe_n,
  input logic [W-1:0] port_b_oe_n,
  input logic         port_a_pull_select,
  input logic         port_b_pull_select,
  input logic         port_a_pull_up,
  input logic         port_b_pull_up,
  input logic         key_wakeup_irq,
  input logic         key_wakeup_stop_wake
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       all_hi;
  logic [4:0] lo_age_r;
  logic [2:0] wr_age_r;
  assign all_hi = &port_a_in[6:0] && &port_b_in;
  // cycles since a wake pin was low or a write; saturate so old causes expire
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lo_age_r <= 5'h00;
      wr_age_r <= 3'h7;
    end else begin
      lo_age_r <= !all_hi ? 5'h00 : lo_age_r + {4'h0, lo_age_r != 5'h1f};
      wr_age_r <= bus_wr ? 3'h0 : wr_age_r + {2'h0, wr_age_r != 3'h7};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  rdata_idle_a: assert property (bus_rdata != 8'h00 |-> $past(bus_rd))
    else $error("read data without a read");
  flag7_zero_a: assert property (bus_rd && bus_addr == `KWIO_OFS_A_FLAG |=> !bus_rdata[7])
    else $error("flag bit 7 read as one");
  unmapped_rd_a: assert property (bus_rd && bus_addr[7:3] != 5'h05 |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  pull_follow_a: assert property ($past(nrst) |-> port_a_pull_up == $past(port_a_pull_select)
    && port_b_pull_up == $past(port_b_pull_select)) else $error("pull does not follow select");
  stop_wake_a: assert property (!stop_mode || all_hi |-> !key_wakeup_stop_wake)
    else $error("stop wake without cause");
  irq_rise_a: assert property ($rose(key_wakeup_irq) |-> lo_age_r != 5'h1f || wr_age_r < 3'h4)
    else $error("request rose without cause");
  irq_fall_a: assert property ($fell(key_wakeup_irq) |-> wr_age_r < 3'h4)
    else $error("request fell without write");
  oe_change_a: assert property ($changed(port_a_oe_n) || $changed(port_b_oe_n) |-> wr_age_r < 3'h2)
    else $error("enable changed without write");
  cover property ($rose(key_wakeup_irq));
  cover property (key_wakeup_stop_wake);
  cover property (bus_rd && bus_addr == `KWIO_OFS_A_FLAG);
endmodule
bind kwio_top kwio_monitor #(.W(W)) i_mon (.clk(clk), .nrst(nrst), .bus_addr(bus_addr),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .stop_mode(stop_mode),
  .port_a_in(port_a_in), .port_b_in(port_b_in), .port_a_oe_n(port_a_oe_n),
  .port_b_oe_n(port_b_oe_n), .port_a_pull_select(port_a_pull_select),
  .port_b_pull_select(port_b_pull_select), .port_a_pull_up(port_a_pull_up),
  .port_b_pull_up(port_b_pull_up), .key_wakeup_irq(key_wakeup_irq),
  .key_wakeup_stop_wake(key_wakeup_stop_wake));

// ===== kwio_keys.sv
module kwio_keys #(
  parameter W = 8
) (
  input  logic [W-1:0] oe_n,
  input  logic [W-1:0] drv,
  input  logic         pull_up,
  input  logic [W-1:0] press,
  output logic [W-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // wired level: a pressed key or a low drive wins, else a high drive or the pull, never floating
  always_comb begin
    for (int i = 0; i < W; i++)
      pin[i] = (press[i] || !oe_n[i] && !drv[i]) ? 1'b0 : (oe_n[i] ? pull_up : drv[i]);
  end
endmodule

// ===== tb_top.sv
`include "kwio_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, nrst = 0, wr_s = 0, rd_s = 0, stop = 0, sel_a = 1, sel_b = 1;
  logic [7:0] addr = 0, wdata = 0, a_key = 0, b_key = 0;
  logic [7:0] rdata, a_in, b_in, a_out, b_out, a_oe_n, b_oe_n;
  logic       a_pu, b_pu, irq, wake;
  int         miscompares = 0, checks_done = 0;
  kwio_top i_dut (.clk(clk), .nrst(nrst), .bus_addr(addr), .bus_wdata(wdata), .bus_wr(wr_s),
    .bus_rd(rd_s), .bus_rdata(rdata), .stop_mode(stop), .port_a_in(a_in), .port_a_out(a_out),
    .port_a_oe_n(a_oe_n), .port_b_in(b_in), .port_b_out(b_out), .port_b_oe_n(b_oe_n),
    .port_a_pull_select(sel_a), .port_b_pull_select(sel_b), .port_a_pull_up(a_pu),
    .port_b_pull_up(b_pu), .key_wakeup_irq(irq), .key_wakeup_stop_wake(wake));
  kwio_keys i_keys_a (.oe_n(a_oe_n), .drv(a_out), .pull_up(a_pu), .press(a_key), .pin(a_in));
  kwio_keys i_keys_b (.oe_n(b_oe_n), .drv(b_out), .pull_up(b_pu), .press(b_key), .pin(b_in));
  // 200 MHz clock
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1;
    @(posedge clk);
    wr_s <= 0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1;
    @(posedge clk);
    rd_s <= 0;
    #1 chk(rdata, exp);
  endtask
  task automatic pulse(input logic [15:0] k, input int n);
    @(posedge clk);
    {a_key, b_key} <= k;
    repeat (n) @(posedge clk);
    {a_key, b_key} <= 16'h0000;
    repeat (8) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: the tests need well under 10 us
  initial begin
    #40000;
    miscompares++;
    $display("Error at %0t: timeout", $time);
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1;
    repeat (4) @(posedge clk);
    for (int a = 8'h2a; a < 8'h30; a++) rd(8'(a), 8'h00);
    wr(`KWIO_OFS_A_DATA, 8'hff);
    wr(`KWIO_OFS_A_DIR, 8'h5a);
    rd(`KWIO_OFS_A_DIR, 8'h5a);
    chk(a_oe_n, 8'ha5);
    rd(`KWIO_OFS_A_DATA, 8'hff);
    // pins driven low as outputs must still flag
    wr(`KWIO_OFS_A_DATA, 8'h00);
    repeat (8) @(posedge clk);
    rd(`KWIO_OFS_A_FLAG, 8'h5a);
    chk({7'h00, irq}, 8'h00);
    wr(`KWIO_OFS_A_EN, 8'h08);
    repeat (3) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    wr(`KWIO_OFS_A_FLAG, 8'h08);
    repeat (3) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    rd(`KWIO_OFS_A_FLAG, 8'h52);
    wr(`KWIO_OFS_A_DIR, 8'h00);
    wr(`KWIO_OFS_A_FLAG, 8'hff);
    wr(`KWIO_OFS_B_EN, 8'hff);
    for (int i = 0; i < 8; i++) begin
      pulse(16'h0001 << i, 3);
      chk({7'h00, irq}, 8'h01);
      rd(`KWIO_OFS_B_FLAG, 8'h01 << i);
      wr(`KWIO_OFS_B_FLAG, 8'h01 << i);
    end
    pulse(16'h8000, 3);
    rd(`KWIO_OFS_A_FLAG, 8'h00);
    // start detection: data fall with clock low is ignored
    wr(`KWIO_OFS_A_EN, 8'hc0);
    a_key <= 8'h80;
    repeat (4) @(posedge clk);
    pulse(16'hc000, 3);
    rd(`KWIO_OFS_A_FLAG, 8'h00);
    pulse(16'h4000, 3);
    rd(`KWIO_OFS_A_FLAG, 8'h40);
    chk({7'h00, irq}, 8'h01);
    wr(`KWIO_OFS_A_DATA, 8'h40);
    wr(`KWIO_OFS_A_DIR, 8'hc0);
    repeat (2) @(posedge clk);
    chk(a_oe_n, 8'h7f);
    wr(`KWIO_OFS_A_DIR, 8'h00);
    wr(`KWIO_OFS_A_EN, 8'h00);
    wr(`KWIO_OFS_B_EN, 8'h00);
    stop <= 1;
    @(posedge clk) b_key <= 8'h01;
    #1 chk({7'h00, wake}, 8'h00);
    pulse(16'h0000, 20);
    wr(`KWIO_OFS_B_FLAG, 8'hff);
    wr(`KWIO_OFS_B_EN, 8'h01);
    @(posedge clk) b_key <= 8'h01;
    #1 chk({7'h00, wake}, 8'h01);
    // a three-cycle low (pressed one cycle before the pulse) passes the synchroniser but not the stop filter's vote
    pulse(16'h0001, 2);
    repeat (20) @(posedge clk);
    rd(`KWIO_OFS_B_FLAG, 8'h00);
    pulse(16'h0001, 20);
    rd(`KWIO_OFS_B_FLAG, 8'h01);
    stop <= 0;
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
    sel_a <= 0;
    sel_b <= 0;
    repeat (3) @(posedge clk);
    chk({6'h00, a_pu, b_pu}, 8'h00);
    print_verdict();
  end
endmodule
